// ==== rtl/status_flags_pkg.sv ====
package status_flags_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_STATUS_ALIAS = 8'h00;
	localparam logic [7:0] ADDR_PRESS_HIGH = 8'h01;
	localparam logic [7:0] ADDR_PRESS_MID = 8'h02;
	localparam logic [7:0] ADDR_PRESS_LOW = 8'h03;
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h04;
	localparam logic [7:0] ADDR_TEMP_LOW = 8'h05;
	localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h06;
	localparam logic [7:0] ADDR_FIFO_STATUS = 8'h0D;
	localparam logic [7:0] ADDR_FIFO_DATA = 8'h0E;
	localparam logic [7:0] ADDR_LAST_AREA_A = 8'h05;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int BIT_ANY_OW = 7;
	localparam int BIT_PRESS_OW = 6;
	localparam int BIT_TEMP_OW = 5;
	localparam int BIT_ANY_DR = 3;
	localparam int BIT_PRESS_DR = 2;
	localparam int BIT_TEMP_DR = 1;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ****************************************
	// Buffering modes and flag indices
	// ****************************************
	localparam logic [1:0] MODE_FIFO_OFF = 2'h0;
	localparam logic [1:0] MODE_CIRCULAR = 2'h1;
	localparam logic [1:0] MODE_STOP_FULL = 2'h2;
	localparam int NUM_FLAGS = 3;
	localparam int FLAG_ANY = 0;
	localparam int FLAG_PRESS = 1;
	localparam int FLAG_TEMP = 2;

endpackage

// ==== rtl/event_flag_pair.sv ====
`timescale 1ns/1ps
// Ready and overwrite pair for one flag group
module event_flag_pair
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic event_in,
	input wire logic clear_in,
	input wire logic replace_in,
	output logic ready_out,
	output logic overwrite_out
);
	logic ready_reg;
	logic ready_next;
	logic overwrite_reg;
	logic overwrite_next;

	// Set beats clear; overwrite when unread data is replaced
	always_comb
	begin
		ready_next = ready_reg;
		overwrite_next = overwrite_reg;
		if (clear_in)
		begin
			ready_next = 1'b0;
			overwrite_next = 1'b0;
		end
		if (enable_in && event_in)
		begin
			ready_next = 1'b1;
		end
		if (enable_in && replace_in)
		begin
			overwrite_next = 1'b1;
		end
	end

	// Flag storage
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			ready_reg <= 1'b0;
			overwrite_reg <= 1'b0;
		end
		else
		begin
			ready_reg <= ready_next;
			overwrite_reg <= overwrite_next;
		end
	end

	assign ready_out = ready_reg;
	assign overwrite_out = overwrite_reg;
endmodule

// ==== rtl/read_pointer.sv ====
`timescale 1ns/1ps
// Auto-increment register pointer for burst reads
module read_pointer
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic [7:0] load_addr_in,
	input wire logic step_in,
	input wire logic fifo_on_in,
	output logic [7:0] addr_out
);
	import status_flags_pkg::*;
	logic [7:0] addr_reg;
	logic [7:0] addr_next;

	// Wrap 05h to 00h; root pointer 01h stays put when buffering
	always_comb
	begin
		addr_next = addr_reg;
		if (load_in)
		begin
			addr_next = load_addr_in;
		end
		else if (step_in)
		begin
			if (addr_reg == ADDR_LAST_AREA_A)
				addr_next = ADDR_STATUS_ALIAS;
			else if (fifo_on_in && addr_reg == ADDR_PRESS_HIGH)
				addr_next = ADDR_PRESS_HIGH;
			else
				addr_next = addr_reg + 8'h01;
		end
	end

	// Pointer storage
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			addr_reg <= BYTE_ZERO;
		else
			addr_reg <= addr_next;
	end

	assign addr_out = addr_reg;
endmodule

// ==== rtl/sample_status_flags.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Mode zero: address 00h reads the sample status at 06h.
// - Mode nonzero: address 00h reads the FIFO status from 0Dh.
// - Sample status follows every pressure and temperature result update.
// - Bits 7,6,5 overwrite; 3,2,1 ready; 4,0 reserved; reset zero, read-only.
// - Combined overwrite sets when a new result replaces an unread one.
// - Mode zero: combined overwrite clears on either result high-byte read.
// - Mode nonzero: all six flags clear on FIFO data port reads.
// - Pressure overwrite sets when new pressure arrives before old was read.
// - Mode zero: pressure overwrite clears on pressure high-byte read.
// - Temperature overwrite sets when new temperature arrives before old read.
// - Mode zero: temperature overwrite clears on temperature high-byte read.
// - Combined ready sets on any new result; clears on high-byte reads.
// - Pressure ready sets per pressure result; clears on its high-byte read.
// - Temperature ready sets per temperature result; clears on its read.
// - Combined flags generated only with data-ready event enable set.
// - Pressure flags generated only with pressure event enable set.
// - Temperature flags generated only with temperature event enable set.
// - Mode zero: result registers show live altitude or pressure data.
// - Status alias lets status and data be read in one burst.
// - Buffering off: six bytes 00h to 05h readable in one transaction.
// - Mode 00 off, 01 circular, 10 stop when full.
module sample_status_flags
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [1:0] buffer_mode_in,
	input wire logic data_ready_event_enable_in,
	input wire logic press_event_enable_in,
	input wire logic temp_event_enable_in,
	input wire logic altitude_select_in,
	input wire logic press_done_in,
	input wire logic temp_done_in,
	input wire logic [19:0] press_data_in,
	input wire logic [19:0] alt_data_in,
	input wire logic [11:0] temp_data_in,
	input wire logic [7:0] fifo_status_in,
	input wire logic [7:0] fifo_data_in,
	input wire logic start_in,
	input wire logic [7:0] start_addr_in,
	input wire logic read_in,
	input wire logic write_in,
	output logic [7:0] read_data_out,
	output logic read_valid_out,
	output logic [7:0] sample_status_out,
	output logic [7:0] addr_out
);
	import status_flags_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic fifo_on;
	logic [7:0] addr;
	logic [NUM_FLAGS-1:0] flag_enable;
	logic [NUM_FLAGS-1:0] flag_event;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flag_replace;
	logic press_unread_reg;
	logic press_unread_next;
	logic temp_unread_reg;
	logic temp_unread_next;
	logic [NUM_FLAGS-1:0] ready_flag;
	logic [NUM_FLAGS-1:0] overwrite_flag;
	logic [7:0] status_word;
	logic press_high_read;
	logic temp_high_read;
	logic fifo_data_read;
	logic [19:0] press_result_reg;
	logic [19:0] press_result_next;
	logic [11:0] temp_result_reg;
	logic [11:0] temp_result_next;
	logic [7:0] read_data_reg;
	logic [7:0] read_data_next;
	logic read_valid_reg;
	logic read_valid_next;
	logic [7:0] status_reg;

	assign fifo_on = (buffer_mode_in == MODE_CIRCULAR) || (buffer_mode_in == MODE_STOP_FULL)
		|| (buffer_mode_in != MODE_FIFO_OFF);

	// ****************************************
	// Burst pointer
	// ****************************************
	// Auto-increment from alias
	read_pointer u_pointer
	(
		.clock_in(clock_in),
		.reset_in(reset_in),
		.load_in(start_in),
		.load_addr_in(start_addr_in),
		.step_in(read_in),
		.fifo_on_in(fifo_on),
		.addr_out(addr)
	);

	// ****************************************
	// Clearing reads
	// ****************************************
	// High-byte reads in mode zero
	assign press_high_read = read_in && !fifo_on && (addr == ADDR_PRESS_HIGH);
	assign temp_high_read = read_in && !fifo_on && (addr == ADDR_TEMP_HIGH);
	// FIFO data port read, at 0Eh or at the root pointer 01h
	assign fifo_data_read = read_in && fifo_on
		&& ((addr == ADDR_FIFO_DATA) || (addr == ADDR_PRESS_HIGH));

	// Enables, events and clears per flag group
	always_comb
	begin
		flag_enable[FLAG_ANY] = data_ready_event_enable_in;
		flag_enable[FLAG_PRESS] = press_event_enable_in;
		flag_enable[FLAG_TEMP] = temp_event_enable_in;
		flag_event[FLAG_ANY] = press_done_in || temp_done_in;
		flag_event[FLAG_PRESS] = press_done_in;
		flag_event[FLAG_TEMP] = temp_done_in;
		flag_clear[FLAG_ANY] = press_high_read || temp_high_read || fifo_data_read;
		flag_clear[FLAG_PRESS] = press_high_read || fifo_data_read;
		flag_clear[FLAG_TEMP] = temp_high_read || fifo_data_read;
		// Combined overwrite only when an unread result is replaced
		flag_replace[FLAG_ANY] = (press_done_in && press_unread_reg)
			|| (temp_done_in && temp_unread_reg);
		flag_replace[FLAG_PRESS] = press_done_in && press_unread_reg;
		flag_replace[FLAG_TEMP] = temp_done_in && temp_unread_reg;
	end

	// Retrieval tracking, apart from the event enables
	always_comb
	begin
		press_unread_next = press_unread_reg;
		temp_unread_next = temp_unread_reg;
		if (flag_clear[FLAG_PRESS])
			press_unread_next = 1'b0;
		if (flag_clear[FLAG_TEMP])
			temp_unread_next = 1'b0;
		// A new result beats a clearing read
		if (press_done_in)
			press_unread_next = 1'b1;
		if (temp_done_in)
			temp_unread_next = 1'b1;
	end

	// ****************************************
	// Flag groups
	// ****************************************
	// Set-over-clear inside each pair
	genvar g;
	generate
		for (g = 0; g < NUM_FLAGS; g++)
		begin : g_flags
			event_flag_pair u_pair
			(
				.clock_in(clock_in),
				.reset_in(reset_in),
				.enable_in(flag_enable[g]),
				.event_in(flag_event[g]),
				.clear_in(flag_clear[g]),
				.replace_in(flag_replace[g]),
				.ready_out(ready_flag[g]),
				.overwrite_out(overwrite_flag[g])
			);
		end
	endgenerate

	always_comb
	begin
		status_word = STATUS_RESET;
		status_word[BIT_ANY_OW] = overwrite_flag[FLAG_ANY];
		status_word[BIT_PRESS_OW] = overwrite_flag[FLAG_PRESS];
		status_word[BIT_TEMP_OW] = overwrite_flag[FLAG_TEMP];
		status_word[BIT_ANY_DR] = ready_flag[FLAG_ANY];
		status_word[BIT_PRESS_DR] = ready_flag[FLAG_PRESS];
		status_word[BIT_TEMP_DR] = ready_flag[FLAG_TEMP];
	end

	// ****************************************
	// Result registers
	// ****************************************
	// Live results, altitude or pressure
	always_comb
	begin
		press_result_next = press_result_reg;
		temp_result_next = temp_result_reg;
		if (press_done_in)
			press_result_next = altitude_select_in ? alt_data_in : press_data_in;
		if (temp_done_in)
			temp_result_next = temp_data_in;
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Six-byte area and status readback
	always_comb
	begin
		read_data_next = read_data_reg;
		read_valid_next = read_in;
		if (read_in)
		begin
			case (addr)
				// Alias to sample status; alias to FIFO status
				ADDR_STATUS_ALIAS: read_data_next = fifo_on ? fifo_status_in : status_word;
				ADDR_PRESS_HIGH: read_data_next = fifo_on ? fifo_data_in
					: press_result_reg[19:12];
				ADDR_PRESS_MID: read_data_next = fifo_on ? BYTE_ZERO : press_result_reg[11:4];
				ADDR_PRESS_LOW: read_data_next = fifo_on ? BYTE_ZERO
					: {press_result_reg[3:0], 4'h0};
				ADDR_TEMP_HIGH: read_data_next = fifo_on ? BYTE_ZERO : temp_result_reg[11:4];
				ADDR_TEMP_LOW: read_data_next = fifo_on ? BYTE_ZERO
					: {temp_result_reg[3:0], 4'h0};
				ADDR_SAMPLE_STATUS: read_data_next = status_word;
				ADDR_FIFO_STATUS: read_data_next = fifo_status_in;
				ADDR_FIFO_DATA: read_data_next = fifo_data_in;
				default: read_data_next = BYTE_ZERO;
			endcase
		end
	end

	// Registered state; write_in reaches no flag
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			press_result_reg <= 20'h00000;
			temp_result_reg <= 12'h000;
			read_data_reg <= BYTE_ZERO;
			read_valid_reg <= 1'b0;
			status_reg <= STATUS_RESET;
			press_unread_reg <= 1'b0;
			temp_unread_reg <= 1'b0;
		end
		else
		begin
			press_result_reg <= press_result_next;
			temp_result_reg <= temp_result_next;
			read_data_reg <= read_data_next;
			read_valid_reg <= read_valid_next;
			status_reg <= status_word;
			press_unread_reg <= press_unread_next;
			temp_unread_reg <= temp_unread_next;
		end
	end

	assign read_data_out = read_data_reg;
	assign read_valid_out = read_valid_reg;
	assign sample_status_out = status_reg;
	assign addr_out = addr;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_press_unread;
		press_event_enable_in && press_done_in && ready_flag[FLAG_PRESS];
	endsequence

	a_press_overwrite: assert property (@(posedge clock_in) disable iff (reset_in)
		s_press_unread |=> overwrite_flag[FLAG_PRESS])
		else $error("pressure overwrite not set");
	a_temp_overwrite: assert property (@(posedge clock_in) disable iff (reset_in)
		temp_event_enable_in && temp_done_in && ready_flag[FLAG_TEMP]
		|=> overwrite_flag[FLAG_TEMP])
		else $error("temperature overwrite not set");
	a_any_ready_set: assert property (@(posedge clock_in) disable iff (reset_in)
		data_ready_event_enable_in && (press_done_in || temp_done_in) |=> ready_flag[FLAG_ANY])
		else $error("combined ready not set");
	a_press_ready_clr: assert property (@(posedge clock_in) disable iff (reset_in)
		press_high_read && !press_done_in |=> !ready_flag[FLAG_PRESS])
		else $error("pressure ready not cleared");
	a_temp_ready_clr: assert property (@(posedge clock_in) disable iff (reset_in)
		temp_high_read && !temp_done_in |=> !ready_flag[FLAG_TEMP])
		else $error("temperature ready not cleared");
	a_fifo_clear_all: assert property (@(posedge clock_in) disable iff (reset_in)
		fifo_data_read && !press_done_in && !temp_done_in |=> status_word == STATUS_RESET)
		else $error("flags not cleared by FIFO read");
	a_enable_gate: assert property (@(posedge clock_in) disable iff (reset_in)
		!press_event_enable_in && !ready_flag[FLAG_PRESS] |=> !ready_flag[FLAG_PRESS])
		else $error("pressure flag set while disabled");
	a_alias_read: assert property (@(posedge clock_in) disable iff (reset_in)
		read_in && addr == ADDR_STATUS_ALIAS && !fifo_on |=> read_data_out == $past(status_word))
		else $error("alias read wrong");
	a_write_inert: assert property (@(posedge clock_in) disable iff (reset_in)
		write_in && !read_in && !press_done_in && !temp_done_in |=> $stable(status_word))
		else $error("write changed flags");

	sequence s_any_press_replace;
		data_ready_event_enable_in && press_done_in && press_unread_reg;
	endsequence

	sequence s_any_temp_replace;
		data_ready_event_enable_in && temp_done_in && temp_unread_reg;
	endsequence

	a_any_ow_press: assert property (@(posedge clock_in) disable iff (reset_in)
		s_any_press_replace |=> overwrite_flag[FLAG_ANY])
		else $error("combined overwrite missed on pressure");
	a_any_ow_temp: assert property (@(posedge clock_in) disable iff (reset_in)
		s_any_temp_replace |=> overwrite_flag[FLAG_ANY])
		else $error("combined overwrite missed on temperature");
	a_any_ow_quiet: assert property (@(posedge clock_in) disable iff (reset_in)
		!(press_done_in && press_unread_reg) && !(temp_done_in && temp_unread_reg)
		&& !overwrite_flag[FLAG_ANY] |=> !overwrite_flag[FLAG_ANY])
		else $error("combined overwrite set without a replace");
	a_status_mirror: assert property (@(posedge clock_in) disable iff (reset_in)
		!reset_in |=> sample_status_out == $past(status_word))
		else $error("status port lags the flags");
	a_fifo_alias: assert property (@(posedge clock_in) disable iff (reset_in)
		read_in && addr == ADDR_STATUS_ALIAS && fifo_on |=> read_data_out == $past(fifo_status_in))
		else $error("alias read wrong while buffering");
	a_any_gate: assert property (@(posedge clock_in) disable iff (reset_in)
		!data_ready_event_enable_in && !ready_flag[FLAG_ANY] |=> !ready_flag[FLAG_ANY])
		else $error("combined flag set while disabled");
endmodule

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
// Host side of the serial register port
module host_model
(
	input wire logic clock_in,
	input wire logic [7:0] read_data_in,
	input wire logic read_valid_in,
	output logic start_out,
	output logic [7:0] addr_out,
	output logic read_out,
	output logic write_out
);
	// Idle port levels
	initial
	begin
		start_out = 1'b0;
		addr_out = 8'h00;
		read_out = 1'b0;
		write_out = 1'b0;
	end

	// Load the pointer; address lines scrambled once released
	task automatic begin_burst(input logic [7:0] a);
		@(posedge clock_in);
		start_out <= 1'b1;
		addr_out <= a;
		@(posedge clock_in);
		start_out <= 1'b0;
		addr_out <= ~a;
	endtask

	task automatic next_byte(output logic [7:0] d, output bit ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		@(posedge clock_in);
		read_out <= 1'b1;
		@(posedge clock_in);
		read_out <= 1'b0;
		for (n = 0; n < 4 && !ok; n++)
		begin
			@(posedge clock_in);
			if (read_valid_in === 1'b1)
			begin
				ok = 1'b1;
				d = read_data_in;
			end
		end
	endtask

	// Register write at the current pointer
	task automatic poke();
		@(posedge clock_in);
		write_out <= 1'b1;
		@(posedge clock_in);
		write_out <= 1'b0;
	endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	import status_flags_pkg::*;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [1:0] mode = MODE_FIFO_OFF;
	logic dr_en = 1'b1;
	logic p_en = 1'b1;
	logic t_en = 1'b1;
	logic alt_sel = 1'b0;
	logic press_done = 1'b0;
	logic temp_done = 1'b0;
	logic start;
	logic [7:0] start_addr;
	logic rd;
	logic wr;
	logic [7:0] read_data;
	logic read_valid;
	logic [7:0] status;
	logic [7:0] ptr;
	int err_count = 0;
	int checks = 0;

	// ****************************************
	// Clock, device and host
	// ****************************************
	always #10 clock_in = ~clock_in;

	sample_status_flags sample_status_flags_inst
	(
		.clock_in(clock_in), .reset_in(reset_in), .buffer_mode_in(mode),
		.data_ready_event_enable_in(dr_en), .press_event_enable_in(p_en),
		.temp_event_enable_in(t_en), .altitude_select_in(alt_sel),
		.press_done_in(press_done), .temp_done_in(temp_done),
		.press_data_in(20'hABCDE), .alt_data_in(20'h12345), .temp_data_in(12'h123),
		.fifo_status_in(8'h5A), .fifo_data_in(8'hC3), .start_in(start),
		.start_addr_in(start_addr), .read_in(rd), .write_in(wr),
		.read_data_out(read_data), .read_valid_out(read_valid),
		.sample_status_out(status), .addr_out(ptr)
	);

	host_model host_model_inst
	(
		.clock_in(clock_in), .read_data_in(read_data), .read_valid_in(read_valid),
		.start_out(start), .addr_out(start_addr), .read_out(rd), .write_out(wr)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One byte, a lost answer ends the run
	task automatic get(output logic [7:0] d);
		bit ok;
		host_model_inst.next_byte(d, ok);
		if (!ok)
		begin
			err_count++;
			summarize();
		end
	endtask

	task automatic peek(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		host_model_inst.begin_burst(a);
		get(d);
		check(what, d, exp);
	endtask

	// Acquisition pulses, then time for the status to settle
	task automatic pulse(input logic p, input logic t);
		@(posedge clock_in);
		press_done <= p;
		temp_done <= t;
		@(posedge clock_in);
		press_done <= 1'b0;
		temp_done <= 1'b0;
		repeat (2) @(posedge clock_in);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic [7:0] d;
		logic [7:0] burst [7];
		logic [2:0] en;
		int i;
		burst = '{8'hCE, 8'hAB, 8'hCD, 8'hE0, 8'h12, 8'h30, 8'h00};
		repeat (16) @(posedge clock_in);
		reset_in <= 1'b0;
		peek(ADDR_SAMPLE_STATUS, STATUS_RESET, "reset status");
		peek(ADDR_STATUS_ALIAS, STATUS_RESET, "reset alias");
		$display("test reset done");
		pulse(1'b1, 1'b0);
		check("status port", status, 8'h0C);
		peek(ADDR_SAMPLE_STATUS, 8'h0C, "press ready");
		pulse(1'b1, 1'b0);
		host_model_inst.poke();
		peek(ADDR_SAMPLE_STATUS, 8'hCC, "press overwrite");
		pulse(1'b0, 1'b1);
		host_model_inst.begin_burst(ADDR_STATUS_ALIAS);
		for (i = 0; i < 7; i++)
		begin
			get(d);
			check("burst byte", d, burst[i]);
		end
		$display("test burst done");
		pulse(1'b0, 1'b1);
		pulse(1'b0, 1'b1);
		peek(ADDR_SAMPLE_STATUS, 8'hAA, "temp overwrite");
		peek(ADDR_TEMP_HIGH, 8'h12, "temp high");
		peek(ADDR_SAMPLE_STATUS, 8'h00, "temp cleared");
		host_model_inst.begin_burst(ADDR_PRESS_HIGH);
		fork
			get(d);
			pulse(1'b1, 1'b0);
		join
		peek(ADDR_SAMPLE_STATUS, 8'h0C, "set over clear");
		peek(ADDR_PRESS_HIGH, 8'hAB, "press high");
		$display("test temperature and priority done");
		for (i = 0; i < 3; i++)
		begin
			en = ~(3'b001 << i);
			dr_en <= en[2];
			p_en <= en[1];
			t_en <= en[0];
			pulse(1'b1, 1'b1);
			peek(ADDR_SAMPLE_STATUS, {4'h0, en, 1'b0}, "gated flags");
			peek(ADDR_PRESS_HIGH, 8'hAB, "press high");
			peek(ADDR_TEMP_HIGH, 8'h12, "temp high");
		end
		dr_en <= 1'b1;
		p_en <= 1'b1;
		t_en <= 1'b1;
		$display("test enables done");
		for (i = 1; i < 3; i++)
		begin
			mode <= i[1:0];
			pulse(1'b1, 1'b1);
			peek(ADDR_STATUS_ALIAS, 8'h5A, "fifo alias");
			peek(ADDR_PRESS_MID, 8'h00, "reserved area");
			peek(ADDR_SAMPLE_STATUS, 8'h0E, "flags before drain");
			peek(ADDR_FIFO_DATA, 8'hC3, "fifo data");
			peek(ADDR_SAMPLE_STATUS, 8'h00, "flags after drain");
		end
		pulse(1'b1, 1'b1);
		host_model_inst.begin_burst(ADDR_PRESS_HIGH);
		get(d);
		check("fifo root", d, 8'hC3);
		get(d);
		check("fifo root again", d, 8'hC3);
		check("fifo pointer", ptr, ADDR_PRESS_HIGH);
		peek(ADDR_SAMPLE_STATUS, 8'h00, "root drain");
		mode <= MODE_FIFO_OFF;
		alt_sel <= 1'b1;
		pulse(1'b1, 1'b0);
		peek(ADDR_PRESS_HIGH, 8'h12, "altitude high");
		peek(ADDR_STATUS_ALIAS, 8'h00, "alias after clear");
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		peek(ADDR_SAMPLE_STATUS, 8'h0E, "no false overwrite");
		$display("test modes done");
		summarize();
	end
endmodule
